// ---- logic/acr_pkg.sv ----
// shared constants and state types of the async receive clock/data recovery block
package acr_pkg;
   // oversampling: samples per bit and first centre sample
   localparam logic [4:0]  SPB_NORMAL = 5'h10;
   localparam logic [4:0]  SPB_DOUBLE = 5'h08;
   localparam logic [4:0]  SF_NORMAL  = 5'h08;
   localparam logic [4:0]  SF_DOUBLE  = 5'h04;
   localparam logic [4:0]  SMP_FIRST  = 5'h01;
   // character plus parity length limits
   localparam logic [3:0]  DLEN_MIN   = 4'h5;
   localparam logic [3:0]  DLEN_MAX   = 4'ha;
   localparam int          DATA_W     = 10;
   localparam int          DIV_W      = 12;
   // reset values
   localparam logic [2:0]  SYNC_RST   = 3'h7;
   localparam logic [DIV_W-1:0] DIV_RST = 12'h000;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_START = 3'b010,
      ST_DATA  = 3'b100
   } acr_state_t;

   typedef struct packed {
      acr_state_t        st;
      logic [2:0]        sync;
      logic              line;
      logic              prev;
      logic [DIV_W-1:0]  div;
      logic              tick;
      logic [4:0]        smp;
      logic [3:0]        bit_cnt;
      logic [1:0]        votes;
      logic [DATA_W-1:0] sh;
      logic [DATA_W-1:0] data;
      logic              fe;
      logic              valid;
   } acr_regs_t;
endpackage

// ---- logic/acr_rx_recovery.sv ----
// async receive front end: start qualification and three-sample bit voting
`timescale 1ns/1ps

// Summary of operation
// R1 - sample the line at 16x baud normally, 8x in double speed.
// R2 - a high-to-low edge on idle line starts detection; first low is sample 1.
// R3 - qualify start on samples 8,9,10 (normal) or 4,5,6 (double speed).
// R4 - two or more high qualification samples: drop as noise, wait for next edge.
// R5 - valid start aligns bit timing; realigned on every frame's start bit.
// R6 - each bit is 16 (or 8) sample states; sample number equals state.
// R7 - bit value is the majority of its three centre samples.
// R8 - recover bits through the first stop bit; further stop bits ignored.
// R9 - stop bit voted the same way; zero sets the frame error flag.
// R10 - new start edge accepted right after the last stop voting sample.
// R11 - frames of five to ten character plus parity bits are handled.
// R12 - far transmitter should keep its rate within about two percent.
// R13 - double speed halves the oversampling divisor from sixteen to eight.
// R14 - frame error flag travels with its frame, one when stop bit was zero.
// R15 - line idles high, sampled once per tick after synchronising.
module acr_rx_recovery (
   input  wire logic        sys_clk,             // system clock, 40 MHz
   input  wire logic        rst_n,               // async reset, active low
   input  wire logic        serial_receive_pin,  // raw serial line from pin
   input  wire logic        double_speed_select, // 1: 8 samples per bit
   input  wire logic [11:0] baud_divisor_value,  // tick every value+1 clocks
   input  wire logic [3:0]  frame_bits,          // character plus parity, 5..10
   output logic      [9:0]  rx_data,             // received bits, first bit in bit 0
   output logic             frame_error_flag,    // stop bit of rx_data was zero
   output logic             rx_valid,            // one-cycle pulse, new frame out
   output logic             rx_busy              // frame in progress
);

   acr_pkg::acr_regs_t q;
   acr_pkg::acr_regs_t n;
   logic [4:0]         spb;
   logic [4:0]         sf;
   logic [3:0]         dlen;
   logic               vote_now;

   // majority of three samples
   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

   // out-of-range lengths are clamped rather than trusted
   function automatic logic [3:0] clamp_len(input logic [3:0] l);
      if (l < acr_pkg::DLEN_MIN) begin
         clamp_len = acr_pkg::DLEN_MIN;
      end else if (l > acr_pkg::DLEN_MAX) begin
         clamp_len = acr_pkg::DLEN_MAX;
      end else begin
         clamp_len = l;
      end
   endfunction

   // mode-dependent sampling geometry
   assign spb = double_speed_select ? acr_pkg::SPB_DOUBLE : acr_pkg::SPB_NORMAL;  // R1 R13
   assign sf = double_speed_select ? acr_pkg::SF_DOUBLE : acr_pkg::SF_NORMAL;     // R3
   assign dlen = clamp_len(frame_bits);                                           // R11
   assign vote_now = maj3(q.votes[0], q.votes[1], q.line);                        // R7

   // next-state logic of the whole receiver
   always_comb begin
      n = q;
      n.valid = 1'b0;
      // three-flop synchroniser; accept a change once the last two agree
      n.sync = {q.sync[1:0], serial_receive_pin};
      if (q.sync[1] == q.sync[2]) begin
         n.line = q.sync[2];                                                      // R15
      end
      // oversampling tick from the baud divider
      n.tick = (q.div == acr_pkg::DIV_RST);
      n.div = n.tick ? baud_divisor_value : q.div - 12'h001;
      if (q.tick) begin
         n.prev = q.line;
         unique case (q.st)
            acr_pkg::ST_IDLE: begin
               if (q.prev && !q.line) begin                                       // R2
                  n.st = acr_pkg::ST_START;
                  // this tick took sample 1, so the next tick takes sample 2
                  n.smp = acr_pkg::SMP_FIRST + 5'h01;
                  n.bit_cnt = 4'h0;
                  n.sh = '0;
               end
            end
            acr_pkg::ST_START: begin
               n.smp = q.smp + 5'h01;
               if (q.smp == sf) begin
                  n.votes[0] = q.line;                                            // R3
               end
               if (q.smp == sf + 5'h01) begin
                  n.votes[1] = q.line;
               end
               if (q.smp == sf + 5'h02 && vote_now) begin
                  n.st = acr_pkg::ST_IDLE;                                        // R4
               end else if (q.smp == spb) begin
                  n.st = acr_pkg::ST_DATA;                                        // R5
                  n.smp = acr_pkg::SMP_FIRST;
               end
            end
            acr_pkg::ST_DATA: begin
               n.smp = (q.smp == spb) ? acr_pkg::SMP_FIRST : q.smp + 5'h01;       // R6
               if (q.smp == sf) begin
                  n.votes[0] = q.line;
               end
               if (q.smp == sf + 5'h01) begin
                  n.votes[1] = q.line;
               end
               if (q.smp == sf + 5'h02) begin
                  if (q.bit_cnt == dlen) begin
                     // first stop bit: later stop bits are simply idle line
                     n.data = q.sh;                                               // R8
                     n.fe = ~vote_now;                                            // R9 R14
                     n.valid = 1'b1;
                     n.st = acr_pkg::ST_IDLE;                                     // R10
                  end else begin
                     n.sh[q.bit_cnt] = vote_now;                                  // R7
                     n.bit_cnt = q.bit_cnt + 4'h1;
                  end
               end
            end
            default: begin
               n.st = acr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // single state register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q.st <= acr_pkg::ST_IDLE;
         q.sync <= acr_pkg::SYNC_RST;
         q.line <= 1'b1;
         q.prev <= 1'b1;
         q.div <= acr_pkg::DIV_RST;
         q.tick <= 1'b0;
         q.smp <= 5'h00;
         q.bit_cnt <= 4'h0;
         q.votes <= 2'h0;
         q.sh <= '0;
         q.data <= '0;
         q.fe <= 1'b0;
         q.valid <= 1'b0;
      end else begin
         q <= n;
      end
   end

   // outputs straight from flops, except rx_busy decoded from the state register
   assign rx_data = q.data;
   assign frame_error_flag = q.fe;
   assign rx_valid = q.valid;
   assign rx_busy = (q.st != acr_pkg::ST_IDLE);

   // sample count never passes the bit length of the current mode
   property p_smp_range;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.st == acr_pkg::ST_DATA) |-> (q.smp >= 5'h01 && q.smp <= spb);
   endproperty
   a_smp_range: assert property (p_smp_range) else $error("sample count out of range"); // R1

   // a falling edge on idle line is sample 1; the next tick takes sample 2
   property p_edge_start;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tick && q.st == acr_pkg::ST_IDLE && q.prev && !q.line)
         |=> (q.st == acr_pkg::ST_START && q.smp == 5'h02);
   endproperty
   a_edge_start: assert property (p_edge_start) else $error("start edge missed"); // R2

   // noise spike rejected at the last qualification sample
   property p_noise;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tick && q.st == acr_pkg::ST_START && q.smp == sf + 5'h02 && vote_now)
         |=> (q.st == acr_pkg::ST_IDLE && !q.valid);
   endproperty
   a_noise: assert property (p_noise) else $error("noisy start not rejected"); // R4

   // valid start enters data recovery at sample 1
   property p_sync;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tick && q.st == acr_pkg::ST_START && q.smp == spb)
         |=> (q.st == acr_pkg::ST_DATA && q.smp == 5'h01 && q.bit_cnt == 4'h0);
   endproperty
   a_sync: assert property (p_sync) else $error("no realignment to start bit"); // R5

   // each data bit is stored as the majority vote
   property p_vote;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tick && q.st == acr_pkg::ST_DATA && q.smp == sf + 5'h02 && q.bit_cnt < dlen)
         |=> (q.sh[$past(q.bit_cnt)] == $past(vote_now));
   endproperty
   a_vote: assert property (p_vote) else $error("data bit differs from vote"); // R7

   // stop vote yields frame out, error flag and immediate return to idle
   property p_stop;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tick && q.st == acr_pkg::ST_DATA && q.smp == sf + 5'h02 && q.bit_cnt == dlen)
         |=> (q.valid && q.fe == !$past(vote_now) && q.st == acr_pkg::ST_IDLE);
   endproperty
   a_stop: assert property (p_stop) else $error("stop bit handling wrong"); // R9 R10

   // bit count stays within the frame length
   property p_len;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.st == acr_pkg::ST_DATA) |-> (q.bit_cnt <= dlen);
   endproperty
   a_len: assert property (p_len) else $error("bit count past frame length"); // R11

   // error flag and data only change together with a new frame
   property p_fe_hold;
      @(posedge sys_clk) disable iff (!rst_n)
      !q.valid |=> (q.valid || ($stable(q.fe) && $stable(q.data)));
   endproperty
   a_fe_hold: assert property (p_fe_hold) else $error("flag moved without frame"); // R14

   // valid is a single-cycle pulse
   property p_pulse;
      @(posedge sys_clk) disable iff (!rst_n)
      q.valid |=> !q.valid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("valid longer than a cycle"); // R8

   // start qualification takes its first vote at sample sf
   property p_first_vote;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tick && q.st == acr_pkg::ST_START && q.smp == sf)
         |=> (q.votes[0] == $past(q.line));
   endproperty
   a_first_vote: assert property (p_first_vote) else $error("first start vote missed"); // R3

   // second qualification vote one sample later
   property p_second_vote;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tick && q.st == acr_pkg::ST_START && q.smp == sf + 5'h01)
         |=> (q.votes[1] == $past(q.line));
   endproperty
   a_second_vote: assert property (p_second_vote) else $error("second start vote missed"); // R3

   // a low majority keeps the start bit and its timing
   property p_start_kept;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tick && q.st == acr_pkg::ST_START && q.smp == sf + 5'h02 && !vote_now)
         |=> (q.st == acr_pkg::ST_START && q.smp == $past(q.smp) + 5'h01);
   endproperty
   a_start_kept: assert property (p_start_kept) else $error("valid start dropped"); // R4 R5

   // one state step per tick inside a bit
   property p_smp_step;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tick && q.st == acr_pkg::ST_DATA && q.smp != spb)
         |=> (q.smp == $past(q.smp) + 5'h01);
   endproperty
   a_smp_step: assert property (p_smp_step) else $error("sample state skipped"); // R6

   // last state of a bit wraps to the first of the next
   property p_smp_wrap;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tick && q.st == acr_pkg::ST_DATA && q.smp == spb)
         |=> (q.smp == acr_pkg::SMP_FIRST);
   endproperty
   a_smp_wrap: assert property (p_smp_wrap) else $error("bit did not wrap"); // R6

   // no bit, start bit included, is longer than the mode's sample count
   property p_span;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.st != acr_pkg::ST_IDLE)
         |-> (q.smp <= spb);
   endproperty
   a_span: assert property (p_span) else $error("bit longer than mode allows"); // R13

   // between ticks the sampler stands still
   property p_hold_no_tick;
      @(posedge sys_clk) disable iff (!rst_n)
      !q.tick
         |=> ($stable(q.st) && $stable(q.smp) && $stable(q.prev));
   endproperty
   a_hold_no_tick: assert property (p_hold_no_tick) else $error("sampler moved off tick"); // R15

   // line follows the synchroniser once its last two flops agree
   property p_line_take;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.sync[1] == q.sync[2])
         |=> (q.line == $past(q.sync[2]));
   endproperty
   a_line_take: assert property (p_line_take) else $error("settled line not taken"); // R15

   // a glitch seen by one flop only does not reach the sampler
   property p_line_keep;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.sync[1] != q.sync[2])
         |=> $stable(q.line);
   endproperty
   a_line_keep: assert property (p_line_keep) else $error("unsettled line taken"); // R15

   // divider counts down between ticks
   property p_div_count;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.div != acr_pkg::DIV_RST)
         |=> (!q.tick && q.div == $past(q.div) - 12'h001);
   endproperty
   a_div_count: assert property (p_div_count) else $error("divider count wrong"); // R1

   // divider end gives one tick and reloads the divisor
   property p_div_reload;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.div == acr_pkg::DIV_RST)
         |=> (q.tick && q.div == $past(baud_divisor_value));
   endproperty
   a_div_reload: assert property (p_div_reload) else $error("divider reload wrong"); // R1 R13

   // a new frame starts from an empty shifter so unused bits read zero
   property p_sh_clear;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.tick && q.st == acr_pkg::ST_IDLE && q.prev && !q.line)
         |=> (q.sh == '0 && q.bit_cnt == 4'h0);
   endproperty
   a_sh_clear: assert property (p_sh_clear) else $error("shifter not cleared"); // R11
endmodule

// ---- bench/acr_tx_model.sv ----
// behavioural remote transmitter driving the serial receive line
`timescale 1ns/1ps
module acr_tx_model (
   input  wire logic sys_clk, // bench clock
   output logic      line     // serial line, idles high
);
   int tck = 1; // sys_clk cycles per oversampling tick
   // idle level high until a frame starts
   initial line = 1'b1;
   // hold one level for n ticks, changed only at falling edges
   task automatic hold(input logic v, input int n);
      line = v;
      repeat (n * tck) @(negedge sys_clk);
   endtask
   // start, d bits lsb first, one stop bit of st ticks, nominal rate only
   task automatic send(input logic [9:0] v, input int d, input logic stop, input int spb,
                       input int st);
      hold(1'b0, spb);
      for (int i = 0; i < d; i++) begin
         hold(v[i], spb);
      end
      hold(stop, st);
      // a zero stop bit is followed by a full idle bit so the break ends
      if (!stop) begin
         hold(1'b1, spb);
      end
   endtask
endmodule

// ---- bench/acr_rx_recovery_tb_top.sv ----
// self-checking bench: random frames through the remote transmitter model
`timescale 1ns/1ps
module acr_rx_recovery_tb_top;
   logic        sys_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic        dss     = 1'b0;
   logic [11:0] bdv     = 12'h000;
   logic [3:0]  fb      = 4'ha;
   logic        line;
   logic [9:0]  rx_data;
   logic        fe;
   logic        rx_valid;
   logic        rx_busy;
   int          n_errors     = 0;
   int          total_checks = 0;
   int          seed         = 32'hbe7c8d83;
   logic [10:0] expq[$];
   always #12.5 sys_clk = ~sys_clk;
   acr_tx_model i_tx (.sys_clk(sys_clk), .line(line));
   acr_rx_recovery i_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .serial_receive_pin(line),
      .double_speed_select(dss), .baud_divisor_value(bdv), .frame_bits(fb),
      .rx_data(rx_data), .frame_error_flag(fe), .rx_valid(rx_valid), .rx_busy(rx_busy));
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // reference: queue of expected {error flag, data}, popped at each new frame
   always @(negedge sys_clk) begin
      if (rx_valid === 1'b1) begin
         chk(11'(expq.size() > 0), 11'h001, "frame without a sent frame");
         if (expq.size() > 0) begin
            chk({fe, rx_data}, expq.pop_front(), "frame");
         end
      end
   end
   // random payload masked to d bits; unused upper bits read back as zero
   task automatic frame(input int d, input logic stop, input int st);
      logic [9:0] v;
      v = 10'($random(seed)) & 10'((1 << d) - 1);
      expq.push_back({~stop, v});
      i_tx.send(v, d, stop, dss ? 8 : 16, st);
   endtask
   // hang guard: a run that overstays counts as a mismatch
   initial begin
      repeat (100000) @(posedge sys_clk);
      n_errors++;
      $display("MISMATCH %0t run did not finish", $time);
      end_sim();
   end
   initial begin
      repeat (6) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (20) @(negedge sys_clk);
      // both sampling rates, every frame length, early next start after stop vote
      for (int m = 0; m < 2; m++) begin
         dss = 1'(m);
         bdv = m ? 12'h002 : 12'h000;
         i_tx.tck = m ? 3 : 1;
         i_tx.hold(1'b1, 16);
         for (int d = 5; d <= 10; d++) begin
            fb = 4'(d);
            frame(d, 1'b1, m ? 6 : 10);
            frame(d, 1'b0, m ? 8 : 16);
         end
         // out-of-range lengths are clamped to the nearest legal one
         fb = 4'hf;
         frame(10, 1'b1, m ? 8 : 16);
         i_tx.hold(1'b1, 8);
         fb = 4'h3;
         frame(5, 1'b1, m ? 8 : 16);
         // short low spike: majority of qualification samples high, dropped
         i_tx.hold(1'b0, m ? 2 : 3);
         i_tx.hold(1'b1, m ? 2 : 4);
         chk(11'(rx_busy), 11'h001, "spike not seen");
         i_tx.hold(1'b1, 16);
         chk(11'(rx_busy), 11'h000, "spike not dropped");
      end
      // drain: every sent frame must come out within the bound
      for (int i = 0; i < 2000 && expq.size() > 0; i++) begin
         @(negedge sys_clk);
      end
      chk(11'(expq.size()), 11'h000, "frames missing");
      end_sim();
   end
endmodule
